// ### inc/csm_defines.svh
// Register indices, field positions, reset values and timing counts for CPU sleep control
`ifndef CSM_DEFINES_SVH
`define CSM_DEFINES_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define CSM_IDX_W              10
`define CSM_IDX_POWER_CONTROL  10'h087
`define CSM_IDX_SLEEP_CONTROL  10'h090
`define CSM_IDX_SLEEP_STATUS   10'h091
`define CSM_ADDR_W             12

// -----------------------------------------------------------------
// power_control fields
// -----------------------------------------------------------------
`define CSM_PC_IDLE_BIT        0
`define CSM_PC_STOP_BIT        1
`define CSM_PC_FLAGS_LSB       2
`define CSM_PC_FLAGS_MSB       6
`define CSM_PC_BAUD_BIT        7
`define CSM_PC_RESET           8'h00

// -----------------------------------------------------------------
// sleep_control and sleep_status fields
// -----------------------------------------------------------------
`define CSM_SC_DOG_EN_BIT      0
`define CSM_SC_LOSS_EN_BIT     1
`define CSM_SC_DOG_LOCK_BIT    2
`define CSM_SC_DOG_KICK_BIT    7
`define CSM_SC_RESET           8'h03
`define CSM_SS_CAUSE_LSB       4
`define CSM_CAUSE_RESET        3'h0

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define CSM_CLK_PERIOD_NS      40
`define CSM_LOSS_TIMEOUT_NS    100000
`define CSM_LOSS_CYCLES        (`CSM_LOSS_TIMEOUT_NS / `CSM_CLK_PERIOD_NS)
`define CSM_DOG_CYCLES         4000
`define CSM_TMO_W              12
`define CSM_RESET_HOLD_CYCLES  3'h4
`define CSM_RESET_VECTOR       16'h0000

// -----------------------------------------------------------------
// Bus responses
// -----------------------------------------------------------------
`define CSM_RESP_OKAY          2'b00
`define CSM_RESP_SLVERR        2'b10

`endif

// ### inc/csm_pkg.sv
// Types shared by the CPU sleep control design
package csm_pkg;

   typedef enum logic [3:0] {
      CSM_RUN   = 4'b0001,
      CSM_IDLE  = 4'b0010,
      CSM_STOP  = 4'b0100,
      CSM_RESET = 4'b1000
   } csm_state_t;

endpackage : csm_pkg

// ### inc/csm_reg_if.sv
// Register access carrier between the bus slave and the sleep controller
`timescale 1ns/10ps
`include "csm_defines.svh"

interface csm_reg_if;
   logic                  wrEn;    // One-cycle write strobe
   logic [`CSM_IDX_W-1:0] wrIdx;   // Write register index
   logic [7:0]            wrData;  // Write data, low byte
   logic                  wrLane;  // Byte lane 0 enabled
   logic                  wrHit;   // Write index is mapped
   logic [`CSM_IDX_W-1:0] rdIdx;   // Read register index
   logic [7:0]            rdData;  // Read data
   logic                  rdHit;   // Read index is mapped

   modport bus  (output wrEn, wrIdx, wrData, wrLane, rdIdx, input wrHit, rdData, rdHit);
   modport regs (input wrEn, wrIdx, wrData, wrLane, rdIdx, output wrHit, rdData, rdHit);
endinterface : csm_reg_if

// ### core/csm_timeout.sv
// Restartable timeout counter with one-cycle expiry pulse
`timescale 1ns/10ps

module csm_timeout #(
   parameter int               WIDTH = 12,
   parameter logic [WIDTH-1:0] LIMIT = '1
) (
   input  wire logic clock,    // System clock
   input  wire logic rst,      // Synchronous reset
   input  wire logic run,      // Count while high
   input  wire logic restart,  // Clear count
   output logic      expired   // Pulse on reaching limit
);
   logic [WIDTH-1:0] count;

   always_ff @(posedge clock) begin
      if (rst || restart || !run) begin
         count   <= '0;
         expired <= 1'b0;
      end else if (count == LIMIT - 1'b1) begin
         count   <= '0;
         expired <= 1'b1;
      end else begin
         count   <= count + 1'b1;
         expired <= 1'b0;
      end
   end
endmodule : csm_timeout

// ### core/csm_axil_slave.sv
// AXI4-Lite slave front end for the sleep control registers
`timescale 1ns/10ps
`include "csm_defines.svh"

module csm_axil_slave (
   input  wire logic                  clock,     // System clock
   input  wire logic                  rst,       // Synchronous reset
   input  wire logic [`CSM_ADDR_W-1:0] awaddr,   // Write address
   input  wire logic                  awvalid,   // Write address valid
   output logic                       awready,   // Write address ready
   input  wire logic [31:0]           wdata,     // Write data
   input  wire logic [3:0]            wstrb,     // Write strobes
   input  wire logic                  wvalid,    // Write data valid
   output logic                       wready,    // Write data ready
   output logic [1:0]                 bresp,     // Write response
   output logic                       bvalid,    // Write response valid
   input  wire logic                  bready,    // Write response ready
   input  wire logic [`CSM_ADDR_W-1:0] araddr,   // Read address
   input  wire logic                  arvalid,   // Read address valid
   output logic                       arready,   // Read address ready
   output logic [31:0]                rdata,     // Read data
   output logic [1:0]                 rresp,     // Read response
   output logic                       rvalid,    // Read data valid
   input  wire logic                  rready,    // Read data ready
   csm_reg_if.bus                     regs       // Register access
);
   logic                   awHeld;
   logic                   wHeld;
   logic [`CSM_ADDR_W-1:0] awLatch;
   logic [7:0]             wLatch;
   logic                   laneLatch;
   logic                   doWrite;

   assign awready = !awHeld && !bvalid;
   assign wready  = !wHeld && !bvalid;
   assign arready = !rvalid;
   assign doWrite = awHeld && wHeld && !bvalid;

   // Misaligned addresses are kept out of the map by the awLatch[1:0] check on wrEn
   assign regs.wrEn   = doWrite && (awLatch[1:0] == 2'b00);
   assign regs.wrIdx  = awLatch[`CSM_ADDR_W-1:2];
   assign regs.wrData = wLatch;
   assign regs.wrLane = laneLatch;
   assign regs.rdIdx  = araddr[`CSM_ADDR_W-1:2];

   always_ff @(posedge clock) begin
      if (rst) begin
         awHeld  <= 1'b0;
         awLatch <= '0;
      end else if (awvalid && awready) begin
         awHeld  <= 1'b1;
         awLatch <= awaddr;
      end else if (doWrite) begin
         awHeld  <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wHeld     <= 1'b0;
         wLatch    <= 8'h00;
         laneLatch <= 1'b0;
      end else if (wvalid && wready) begin
         wHeld     <= 1'b1;
         wLatch    <= wdata[7:0];
         laneLatch <= wstrb[0];
      end else if (doWrite) begin
         wHeld     <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= `CSM_RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= (regs.wrHit && awLatch[1:0] == 2'b00) ? `CSM_RESP_OKAY : `CSM_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `CSM_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         if (regs.rdHit && araddr[1:0] == 2'b00) begin
            rdata <= {24'h00_0000, regs.rdData};
            rresp <= `CSM_RESP_OKAY;
         end else begin
            rdata <= 32'h0000_0000;
            rresp <= `CSM_RESP_SLVERR;
         end
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : csm_axil_slave

// ### core/csm_sleep_ctrl.sv
// CPU idle and stop mode controller with watchdog and missing-clock wake paths
`timescale 1ns/10ps
`include "csm_defines.svh"

//Function
// [R1] Idle select halts CPU after instruction; peripherals run
// [R2] Idle keeps all register and memory contents
// [R3] Enabled interrupt or reset pin ends idle
// [R4] Interrupt wake clears idle select, services interrupt
// [R5] After return, resume after idle-setting instruction
// [R6] Reset ending sleep restarts at address zero
// [R7] Software follows idle write with multi-byte instruction
// [R8] Enabled watchdog counts in idle, resets
// [R9] Software may disable watchdog only if allowed
// [R10] Stop select halts CPU, oscillators, clocked peripherals
// [R11] Only a reset exits stop mode
// [R12] Missing-clock detector reset ends stop mode
// [R13] Software powers down analog blocks before stop
// [R14] Oscillator off: only reset resumes operation
// [R15] Power control at index 87h, resets zero
// [R16] Mode bits read zero; upper bits plain flags
module csm_sleep_ctrl
   import csm_pkg::*;
(
   input  wire logic                   clock,            // System clock, 25 MHz
   input  wire logic                   rst,              // Synchronous reset, active high
   input  wire logic [`CSM_ADDR_W-1:0] awaddr,           // AXI write address
   input  wire logic                   awvalid,          // AXI write address valid
   output logic                        awready,          // AXI write address ready
   input  wire logic [31:0]            wdata,            // AXI write data
   input  wire logic [3:0]             wstrb,            // AXI write strobes
   input  wire logic                   wvalid,           // AXI write data valid
   output logic                        wready,           // AXI write data ready
   output logic [1:0]                  bresp,            // AXI write response
   output logic                        bvalid,           // AXI write response valid
   input  wire logic                   bready,           // AXI write response ready
   input  wire logic [`CSM_ADDR_W-1:0] araddr,           // AXI read address
   input  wire logic                   arvalid,          // AXI read address valid
   output logic                        arready,          // AXI read address ready
   output logic [31:0]                 rdata,            // AXI read data
   output logic [1:0]                  rresp,            // AXI read response
   output logic                        rvalid,           // AXI read data valid
   input  wire logic                   rready,           // AXI read data ready
   input  wire logic                   instrDone,        // CPU finished an instruction
   input  wire logic                   irqPending,       // An enabled interrupt is asserted
   input  wire logic                   rstPinN,          // External reset pin, active low
   output logic                        cpuClockEnable,   // CPU may advance
   output logic                        periphClockEnable,// Peripheral clocks run
   output logic                        oscillatorEnable, // Oscillator powered
   output logic                        coreReset,        // Reset to CPU and peripherals
   output logic [15:0]                 resetVector,      // Fetch address after reset
   output logic                        wakeInterrupt,    // Pulse: idle ended by interrupt
   output logic                        serialBaudDouble, // Serial baud doubling flag
   output logic [4:0]                  generalFlags      // Software flags
);

   // -----------------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------------
   csm_reg_if regBus ();

   csm_axil_slave u_slave (
      .clock   (clock),
      .rst     (rst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .regs    (regBus.bus)
   );

   // -----------------------------------------------------------------
   // State and register storage
   // -----------------------------------------------------------------
   csm_state_t state;
   csm_state_t next_state;
   logic       idleSelect;
   logic       stopSelect;
   logic       dogEnable;
   logic       lossEnable;
   logic       dogLock;
   logic [2:0] resetCause;
   logic [2:0] holdCount;
   logic       dogExpired;
   logic       lossExpired;
   logic       pinReset;
   logic       sysReset;
   logic       wrPower;
   logic       wrSleep;
   logic       dogKick;
   logic       idleWake;

   assign pinReset = !rstPinN;
   // Any reset source returns everything to the reset sequence
   assign sysReset = pinReset || dogExpired || lossExpired;  // [R3] [R8] [R11] [R12]
   assign wrPower  = regBus.wrEn && regBus.wrLane
                     && regBus.wrIdx == `CSM_IDX_POWER_CONTROL;
   assign wrSleep  = regBus.wrEn && regBus.wrLane
                     && regBus.wrIdx == `CSM_IDX_SLEEP_CONTROL;
   assign dogKick  = wrSleep && regBus.wrData[`CSM_SC_DOG_KICK_BIT];
   assign idleWake = state == CSM_IDLE && irqPending && !sysReset;  // [R3]

   // -----------------------------------------------------------------
   // Mode state machine
   // -----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         CSM_RUN: begin
            // Stop is the deeper mode, so it wins when both are set
            if (sysReset)
               next_state = CSM_RESET;
            else if (instrDone && stopSelect)
               next_state = CSM_STOP;                         // [R10]
            else if (instrDone && idleSelect)
               next_state = CSM_IDLE;                         // [R1]
         end
         CSM_IDLE: begin
            if (sysReset)
               next_state = CSM_RESET;                        // [R3] [R8]
            else if (irqPending)
               next_state = CSM_RUN;                          // [R4]
         end
         CSM_STOP: begin
            // Interrupts are ignored here; oscillator is off
            if (sysReset)
               next_state = CSM_RESET;                        // [R11] [R14]
         end
         CSM_RESET: begin
            if (holdCount == 3'h0 && !pinReset)
               next_state = CSM_RUN;                          // [R6]
         end
         default: next_state = CSM_RESET;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst)
         state <= CSM_RESET;
      else
         state <= next_state;
   end

   always_ff @(posedge clock) begin
      if (rst || sysReset)
         holdCount <= `CSM_RESET_HOLD_CYCLES;
      else if (state == CSM_RESET && holdCount != 3'h0)
         holdCount <= holdCount - 3'h1;
   end

   // -----------------------------------------------------------------
   // power_control
   // -----------------------------------------------------------------
   // Hardware clear on wake loses to a software set in the same cycle
   always_ff @(posedge clock) begin
      if (rst || sysReset) begin
         idleSelect <= 1'(`CSM_PC_RESET >> `CSM_PC_IDLE_BIT);   // [R15]
      end else if (wrPower && regBus.wrData[`CSM_PC_IDLE_BIT]) begin
         idleSelect <= 1'b1;                                 // [R1]
      end else if (idleWake) begin
         idleSelect <= 1'b0;                                 // [R4]
      end else if (wrPower) begin
         idleSelect <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || sysReset)
         stopSelect <= 1'(`CSM_PC_RESET >> `CSM_PC_STOP_BIT);   // [R15]
      else if (wrPower)
         stopSelect <= regBus.wrData[`CSM_PC_STOP_BIT];     // [R10]
   end

   always_ff @(posedge clock) begin
      if (rst || sysReset) begin
         serialBaudDouble <= 1'b0;                           // [R15]
         generalFlags     <= 5'h00;
      end else if (wrPower) begin
         serialBaudDouble <= regBus.wrData[`CSM_PC_BAUD_BIT]; // [R16]
         generalFlags     <= regBus.wrData[`CSM_PC_FLAGS_MSB:`CSM_PC_FLAGS_LSB];
      end
   end

   // -----------------------------------------------------------------
   // sleep_control and reset cause
   // -----------------------------------------------------------------
   // Lock stops software from switching the watchdog off until reset
   always_ff @(posedge clock) begin
      if (rst || sysReset) begin
         dogEnable  <= 1'(`CSM_SC_RESET >> `CSM_SC_DOG_EN_BIT);
         lossEnable <= 1'(`CSM_SC_RESET >> `CSM_SC_LOSS_EN_BIT);
         dogLock    <= 1'(`CSM_SC_RESET >> `CSM_SC_DOG_LOCK_BIT);
      end else if (wrSleep) begin
         dogEnable  <= regBus.wrData[`CSM_SC_DOG_EN_BIT] || dogLock;  // [R9]
         lossEnable <= regBus.wrData[`CSM_SC_LOSS_EN_BIT];            // [R12]
         dogLock    <= regBus.wrData[`CSM_SC_DOG_LOCK_BIT] || dogLock;
      end
   end

   always_ff @(posedge clock) begin
      if (rst)
         resetCause <= `CSM_CAUSE_RESET;
      else if (sysReset)
         resetCause <= {lossExpired, dogExpired, pinReset};
   end

   // -----------------------------------------------------------------
   // Watchdog and missing-clock detector
   // -----------------------------------------------------------------
   // Watchdog is a timer: it keeps running in idle but is held at zero in stop
   csm_timeout #(
      .WIDTH (`CSM_TMO_W),
      .LIMIT (`CSM_TMO_W'(`CSM_DOG_CYCLES))
   ) u_dog (
      .clock   (clock),
      .rst     (rst),
      .run     (dogEnable && (state == CSM_RUN || state == CSM_IDLE)),  // [R8]
      .restart (dogKick || sysReset),
      .expired (dogExpired)
   );

   // System clock is absent in stop; detector times out on that
   csm_timeout #(
      .WIDTH (`CSM_TMO_W),
      .LIMIT (`CSM_TMO_W'(`CSM_LOSS_CYCLES))
   ) u_loss (
      .clock   (clock),
      .rst     (rst),
      .run     (lossEnable && state == CSM_STOP),             // [R12]
      .restart (sysReset),
      .expired (lossExpired)
   );

   // -----------------------------------------------------------------
   // Register write hits and reads
   // -----------------------------------------------------------------
   assign regBus.wrHit = regBus.wrIdx == `CSM_IDX_POWER_CONTROL
                         || regBus.wrIdx == `CSM_IDX_SLEEP_CONTROL
                         || regBus.wrIdx == `CSM_IDX_SLEEP_STATUS;

   always_comb begin
      regBus.rdHit  = 1'b1;
      regBus.rdData = 8'h00;
      case (regBus.rdIdx)
         `CSM_IDX_POWER_CONTROL:
            regBus.rdData = {serialBaudDouble, generalFlags, 2'b00};  // [R16]
         `CSM_IDX_SLEEP_CONTROL:
            regBus.rdData = {5'h00, dogLock, lossEnable, dogEnable};
         `CSM_IDX_SLEEP_STATUS:
            regBus.rdData = {1'b0, resetCause, state};
         default:
            regBus.rdHit = 1'b0;
      endcase
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // CPU clock gating freezes its state without touching storage
   always_ff @(posedge clock) begin
      if (rst) begin
         cpuClockEnable    <= 1'b0;
         periphClockEnable <= 1'b0;
         oscillatorEnable  <= 1'b1;
         coreReset         <= 1'b1;
      end else begin
         cpuClockEnable    <= next_state == CSM_RUN;          // [R1] [R2] [R10]
         periphClockEnable <= next_state == CSM_RUN
                              || next_state == CSM_IDLE;      // [R1] [R10]
         oscillatorEnable  <= next_state != CSM_STOP;         // [R10] [R14]
         coreReset         <= next_state == CSM_RESET;        // [R6]
      end
   end

   always_ff @(posedge clock) begin
      if (rst)
         wakeInterrupt <= 1'b0;
      else
         wakeInterrupt <= idleWake;                           // [R4] [R5]
   end

   always_ff @(posedge clock) begin
      if (rst)
         resetVector <= `CSM_RESET_VECTOR;
      else if (state == CSM_RESET)
         resetVector <= `CSM_RESET_VECTOR;                    // [R6]
   end

endmodule : csm_sleep_ctrl

// ### test/csm_sleep_ctrl_monitor.sv
// Port-level checks on the sleep controller
`timescale 1ns/10ps
module csm_sleep_ctrl_monitor (
   input wire logic        clock,             // System clock
   input wire logic        rst,               // Synchronous reset
   input wire logic        rstPinN,           // Reset pin
   input wire logic        irqPending,        // Enabled interrupt
   input wire logic        rvalid,            // Read data valid
   input wire logic [31:0] rdata,             // Read data
   input wire logic        cpuClockEnable,    // CPU runs
   input wire logic        periphClockEnable, // Peripherals run
   input wire logic        oscillatorEnable,  // Oscillator on
   input wire logic        coreReset,         // Core reset
   input wire logic [15:0] resetVector,       // Fetch address
   input wire logic        wakeInterrupt      // Wake pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_vec; resetVector == 16'h0000; endproperty
   a_vec: assert property (p_vec) else $error("reset vector not zero");
   property p_pinRst; !rstPinN |=> coreReset && !cpuClockEnable; endproperty
   a_pinRst: assert property (p_pinRst) else $error("pin did not reset");
   property p_rstHold; $fell(rst) |-> coreReset [*3]; endproperty
   a_rstHold: assert property (p_rstHold) else $error("reset sequence short");
   // Idle is the only state with peripherals on and CPU off
   property p_wake;
      !cpuClockEnable && periphClockEnable && irqPending && rstPinN |=> cpuClockEnable;
   endproperty
   a_wake: assert property (p_wake) else $error("interrupt did not end idle");
   property p_wakeOne; wakeInterrupt |=> !wakeInterrupt; endproperty
   a_wakeOne: assert property (p_wakeOne) else $error("wake pulse too long");
   property p_idleClk; periphClockEnable && !cpuClockEnable |-> oscillatorEnable; endproperty
   a_idleClk: assert property (p_idleClk) else $error("idle stopped oscillator");
   property p_stopIrq;
      !oscillatorEnable && rstPinN |=> !cpuClockEnable && !wakeInterrupt;
   endproperty
   a_stopIrq: assert property (p_stopIrq) else $error("stop left without reset");
   property p_stopAll; !oscillatorEnable |-> !periphClockEnable && !cpuClockEnable; endproperty
   a_stopAll: assert property (p_stopAll) else $error("stop left clocks on");
   property p_rdHi; rvalid |-> rdata[31:8] == 24'h000000; endproperty
   a_rdHi: assert property (p_rdHi) else $error("upper read bits set");
   c_wake: cover property (wakeInterrupt);
   c_stop: cover property (!oscillatorEnable);
   c_idle: cover property (periphClockEnable && !cpuClockEnable);
endmodule : csm_sleep_ctrl_monitor

bind csm_sleep_ctrl csm_sleep_ctrl_monitor mon (.clock(clock), .rst(rst), .rstPinN(rstPinN),
   .irqPending(irqPending), .rvalid(rvalid), .rdata(rdata), .cpuClockEnable(cpuClockEnable),
   .periphClockEnable(periphClockEnable), .oscillatorEnable(oscillatorEnable),
   .coreReset(coreReset), .resetVector(resetVector), .wakeInterrupt(wakeInterrupt));

// ### test/csm_sleep_ctrl_test.sv
// Self-checking bench for the sleep controller
`timescale 1ns/10ps
`include "csm_defines.svh"
module csm_sleep_ctrl_test;
   logic clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic instrDone = 0, irqPending = 0, rstPinN = 1;
   logic [`CSM_ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, got;
   logic [3:0]  wstrb = '0;
   logic [1:0]  bresp, rresp, resp;
   logic        awready, wready, bvalid, arready, rvalid, cpuClockEnable, periphClockEnable;
   logic        oscillatorEnable, coreReset, wakeInterrupt, serialBaudDouble;
   logic [15:0] resetVector;
   logic [4:0]  generalFlags;
   int          fails = 0, checked = 0, wakes = 0;
   localparam logic [9:0] PC = `CSM_IDX_POWER_CONTROL, SC = `CSM_IDX_SLEEP_CONTROL;
   csm_sleep_ctrl uut (.clock, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .instrDone, .irqPending, .rstPinN, .cpuClockEnable, .periphClockEnable,
      .oscillatorEnable, .coreReset, .resetVector, .wakeInterrupt, .serialBaudDouble,
      .generalFlags);
   always #20 clock = ~clock;
   always @(posedge clock) if (wakeInterrupt === 1'b1) wakes <= wakes + 1;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task results;
      $display("fails=%0d checked=%0d", fails, checked);
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // Ready is sampled mid-cycle, where it is settled
   task bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
      logic a, w, q, b;
      @(posedge clock);
      awaddr <= {idx, 2'b00};
      araddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      {awvalid, wvalid, bready} <= {3{wr}};
      {arvalid, rready} <= {2{!wr}};
      repeat (50) begin
         @(negedge clock);
         a = awvalid && awready;
         w = wvalid && wready;
         q = arvalid && arready;
         b = (bvalid && bready) || (rvalid && rready);
         got = rdata;
         resp = wr ? bresp : rresp;
         @(posedge clock);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (q) arvalid <= 1'b0;
         if (b) begin
            {bready, rready} <= 2'b00;
            return;
         end
      end
      fails++;
      results;
   endtask : bus
   task rdChk(input logic [9:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk(got, {24'h000000, e});
   endtask : rdChk
   // Bit 2 is the pin (low when set), bit 1 interrupt, bit 0 instruction done
   task pulse(input logic [2:0] m);
      @(posedge clock);
      {rstPinN, irqPending, instrDone} <= {!m[2], m[1:0]};
      @(posedge clock);
      {rstPinN, irqPending, instrDone} <= 3'b100;
      #1;
   endtask : pulse
   task waitRst(input logic lvl);
      repeat (5000) begin
         @(posedge clock);
         #1;
         if (coreReset === lvl) return;
      end
      fails++;
      results;
   endtask : waitRst
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      waitRst(1'b0);
      rdChk(PC, `CSM_PC_RESET);
      rdChk(SC, `CSM_SC_RESET);
      bus(1'b0, 10'h000, 8'h00);
      chk(resp, `CSM_RESP_SLVERR);
      bus(1'b1, PC, 8'hfd);
      chk(resp, `CSM_RESP_OKAY);
      rdChk(PC, 8'hfc);
      chk({serialBaudDouble, generalFlags}, 6'h3f);
      pulse(3'b001);
      chk({cpuClockEnable, periphClockEnable, oscillatorEnable}, 3'b011);
      rdChk(PC, 8'hfc);
      pulse(3'b010);
      chk(cpuClockEnable, 1'b1);
      repeat (3) @(posedge clock);
      chk(wakes, 1);
      pulse(3'b001);
      chk(cpuClockEnable, 1'b1);
      rdChk(PC, 8'hfc);
      bus(1'b1, PC, 8'h01);
      pulse(3'b001);
      pulse(3'b100);
      chk(coreReset, 1'b1);
      waitRst(1'b0);
      rdChk(PC, 8'h00);
      chk(resetVector, `CSM_RESET_VECTOR);
      bus(1'b1, PC, 8'h01);
      pulse(3'b001);
      waitRst(1'b1);
      waitRst(1'b0);
      rdChk(`CSM_IDX_SLEEP_STATUS, 8'h21);
      bus(1'b1, SC, 8'h00);
      bus(1'b1, PC, 8'h02);
      pulse(3'b001);
      chk({cpuClockEnable, periphClockEnable, oscillatorEnable}, 3'b000);
      pulse(3'b010);
      chk(cpuClockEnable, 1'b0);
      repeat (3000) @(posedge clock);
      chk(coreReset, 1'b0);
      pulse(3'b100);
      chk(coreReset, 1'b1);
      waitRst(1'b0);
      bus(1'b1, SC, 8'h02);
      bus(1'b1, PC, 8'h02);
      pulse(3'b001);
      waitRst(1'b1);
      waitRst(1'b0);
      rdChk(`CSM_IDX_SLEEP_STATUS, 8'h41);
      bus(1'b1, SC, 8'h05);
      bus(1'b1, SC, 8'h00);
      rdChk(SC, 8'h05);
      results;
   end
endmodule : csm_sleep_ctrl_test
